// ### hdl/pmcs_duty_decode.sv
// Dimming code to duty percentage decoder
`timescale 1ns/1ps
`include "pmcs_map.svh"

module pmcs_duty_decode (
  input wire logic [6:0] i_code,
  output logic [6:0] o_percent
);

  // code plus one, high codes off
  always_comb begin
    if (i_code <= `PMCS_DUTY_LAST_CODE) begin
      o_percent = 7'(i_code + `PMCS_DUTY_ONE);
    end else begin
      o_percent = `PMCS_DUTY_OFF;
    end
  end

endmodule

// ### hdl/pmcs_regs.sv
// Control, status and write-unlock register bank behind the serial port
`timescale 1ns/1ps
`include "pmcs_map.svh"

module pmcs_regs (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_xfer_done,
  input wire logic i_power_enable_in,
  input wire logic i_adapter_present,
  input wire logic i_usb_supply_present,
  input wire logic i_button_input,
  input wire logic [6:0] i_rail_good,
  output logic [7:0] o_rdata,
  output logic [6:0] o_duty_percent,
  output logic [2:0] o_monitor_select_code,
  output logic o_mux_enable,
  output logic [4:0] o_mux_source,
  output logic o_off_enter,
  output logic o_prot_wr_en,
  output logic [7:0] o_prot_wr_addr,
  output logic [7:0] o_prot_wr_data
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_protected(input logic [7:0] addr);
    return (addr >= `PMCS_PROT_LO) && (addr <= `PMCS_PROT_HI);
  endfunction

  logic [6:0] duty_reg, duty_next;
  pmcs_pkg::pmcs_mux_t sel_reg, sel_next;
  logic off_reg, off_next;
  logic [7:0] unlock_reg, unlock_next;
  pmcs_pkg::pmcs_lock_t lock_reg, lock_next;
  logic fresh_reg, fresh_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [6:0] pct_reg, pct_next;
  logic [4:0] src_reg, src_next;
  logic en_reg, en_next;
  logic offe_reg, offe_next;
  logic pwe_reg, pwe_next;
  logic [7:0] pwa_reg, pwa_next;
  logic [7:0] pwd_reg, pwd_next;
  logic [7:0] status_byte;
  logic [6:0] pct_comb;
  logic unlocked;

  pmcs_duty_decode u_duty (
    .i_code(duty_next),
    .o_percent(pct_comb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Live status image
  always_comb begin
    status_byte = `PMCS_RESET_BYTE;
    status_byte[`PMCS_BIT_OFF] = off_reg;
    status_byte[`PMCS_BIT_ADAPTER] = i_adapter_present;
    status_byte[`PMCS_BIT_USB] = i_usb_supply_present;
    status_byte[`PMCS_BIT_BUTTON] = ~i_button_input;
  end

  assign unlocked = (unlock_reg == `PMCS_UNLOCK_CODE) && fresh_reg;

  ////////////////////////////////////////////////////////////////////////
  // Configuration, status and protected-write path
  always_comb begin
    duty_next = duty_reg;
    sel_next = sel_reg;
    off_next = off_reg;
    offe_next = 1'b0;
    pwe_next = 1'b0;
    pwa_next = pwa_reg;
    pwd_next = pwd_reg;
    // act on request once enable is low
    if (off_reg && !i_power_enable_in) begin
      offe_next = 1'b1;
      off_next = 1'b0;
    end
    if (i_wr_en) begin
      case (i_addr)
        `PMCS_ADDR_DUTY: begin
          duty_next = i_wdata[6:0];
        end
        `PMCS_ADDR_MUX: begin
          sel_next = pmcs_pkg::pmcs_mux_t'(i_wdata[2:0]);
        end
        `PMCS_ADDR_STATUS: begin
          // host write of one sets request, set wins
          if (i_wdata[`PMCS_BIT_OFF]) begin
            off_next = 1'b1;
          end
        end
        default: begin
          // fresh unlock lets this write through
          if (is_protected(i_addr) && unlocked) begin
            pwe_next = 1'b1;
            pwa_next = i_addr;
            pwd_next = i_wdata;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unlock register sequencing
  always_comb begin
    unlock_next = unlock_reg;
    lock_next = lock_reg;
    fresh_next = fresh_reg;
    case (lock_reg)
      pmcs_pkg::PMCS_LOCKED: begin
      end
      pmcs_pkg::PMCS_ARMED: begin
        if (i_xfer_done) begin
          lock_next = pmcs_pkg::PMCS_OPEN;
        end
      end
      pmcs_pkg::PMCS_OPEN: begin
        if (i_xfer_done) begin
          lock_next = pmcs_pkg::PMCS_LOCKED;
          unlock_next = `PMCS_RESET_BYTE;
          fresh_next = 1'b0;
        end
      end
      default: begin
        lock_next = pmcs_pkg::PMCS_LOCKED;
      end
    endcase
    if (i_wr_en) begin
      if (i_addr == `PMCS_ADDR_UNLOCK) begin
        unlock_next = i_wdata;
        fresh_next = 1'b1;
        lock_next = pmcs_pkg::PMCS_ARMED;
      end else begin
        fresh_next = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and read data
  always_comb begin
    pct_next = pct_comb;
    rdata_next = rdata_reg;
    if (i_rd_en) begin
      case (i_addr)
        `PMCS_ADDR_DUTY: rdata_next = {1'b0, duty_reg};
        `PMCS_ADDR_MUX: rdata_next = {5'h00, sel_reg};
        `PMCS_ADDR_STATUS: rdata_next = status_byte;
        `PMCS_ADDR_UNLOCK: rdata_next = unlock_reg;
        `PMCS_ADDR_RAILGOOD: rdata_next = {1'b0, i_rail_good};
        default: rdata_next = `PMCS_RESET_BYTE;
      endcase
    end
  end

  always_comb begin
    en_next = 1'b0;
    src_next = 5'h00;
    case (sel_next)
      pmcs_pkg::PMCS_MUX_BATT: src_next = 5'h01;
      pmcs_pkg::PMCS_MUX_SYS: src_next = 5'h02;
      pmcs_pkg::PMCS_MUX_TEMP: src_next = 5'h04;
      pmcs_pkg::PMCS_MUX_CHG: src_next = 5'h08;
      pmcs_pkg::PMCS_MUX_EXT: src_next = 5'h10;
      default: src_next = 5'h00;
    endcase
    en_next = |src_next;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      duty_reg <= `PMCS_RESET_DUTY;
      sel_reg <= pmcs_pkg::PMCS_MUX_OFF;
      off_reg <= 1'b0;
      unlock_reg <= `PMCS_RESET_BYTE;
      lock_reg <= pmcs_pkg::PMCS_LOCKED;
      fresh_reg <= 1'b0;
      rdata_reg <= `PMCS_RESET_BYTE;
      pct_reg <= `PMCS_DUTY_ONE;
      src_reg <= 5'h00;
      en_reg <= 1'b0;
      offe_reg <= 1'b0;
      pwe_reg <= 1'b0;
      pwa_reg <= `PMCS_RESET_BYTE;
      pwd_reg <= `PMCS_RESET_BYTE;
    end else begin
      duty_reg <= duty_next;
      sel_reg <= sel_next;
      off_reg <= off_next;
      unlock_reg <= unlock_next;
      lock_reg <= lock_next;
      fresh_reg <= fresh_next;
      rdata_reg <= rdata_next;
      pct_reg <= pct_next;
      src_reg <= src_next;
      en_reg <= en_next;
      offe_reg <= offe_next;
      pwe_reg <= pwe_next;
      pwa_reg <= pwa_next;
      pwd_reg <= pwd_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_duty_percent = pct_reg;
  assign o_monitor_select_code = sel_reg;
  assign o_mux_enable = en_reg;
  assign o_mux_source = src_reg;
  assign o_off_enter = offe_reg;
  assign o_prot_wr_en = pwe_reg;
  assign o_prot_wr_addr = pwa_reg;
  assign o_prot_wr_data = pwd_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_duty_map;
    (duty_reg <= `PMCS_DUTY_LAST_CODE) ? (pct_reg == 7'(duty_reg + 7'h01))
                                       : (pct_reg == 7'h00);
  endproperty
  a_duty_map: assert property (p_duty_map)
    else $error("duty percent wrong");

  property p_duty_rd;
    i_rd_en && i_addr == `PMCS_ADDR_DUTY |=> !o_rdata[7];
  endproperty
  a_duty_rd: assert property (p_duty_rd)
    else $error("duty reserved bit set");

  property p_mux_off;
    (sel_reg == 3'h0 || sel_reg == 3'h6 || sel_reg == 3'h7)
      |-> !o_mux_enable && o_mux_source == 5'h00;
  endproperty
  a_mux_off: assert property (p_mux_off)
    else $error("mux not disabled");

  property p_mux_route;
    (sel_reg == 3'h3) |-> o_mux_enable && o_mux_source == 5'h04;
  endproperty
  a_mux_route: assert property (p_mux_route)
    else $error("mux route wrong");

  property p_off_act;
    off_reg && !i_power_enable_in |=> o_off_enter;
  endproperty
  a_off_act: assert property (p_off_act)
    else $error("off not entered");

  property p_off_clr;
    o_off_enter && !$past(i_wr_en) |-> !off_reg;
  endproperty
  a_off_clr: assert property (p_off_clr)
    else $error("off bit not cleared");

  property p_status_rd;
    i_rd_en && i_addr == `PMCS_ADDR_STATUS |=>
      o_rdata[3] == $past(i_adapter_present) &&
      o_rdata[2] == $past(i_usb_supply_present) &&
      o_rdata[0] == !$past(i_button_input);
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status read wrong");

  property p_lock;
    o_prot_wr_en |-> $past(unlock_reg) == 8'h7D && $past(fresh_reg);
  endproperty
  a_lock: assert property (p_lock)
    else $error("protected write while locked");

  property p_unlock_go;
    i_wr_en && is_protected(i_addr) && unlocked |=> o_prot_wr_en;
  endproperty
  a_unlock_go: assert property (p_unlock_go)
    else $error("unlocked write dropped");

  property p_clear;
    lock_reg == pmcs_pkg::PMCS_OPEN && i_xfer_done && !i_wr_en
      |=> unlock_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("unlock not cleared");

  property p_drop;
    i_wr_en && is_protected(i_addr) && !unlocked |=> !o_prot_wr_en;
  endproperty
  a_drop: assert property (p_drop)
    else $error("locked write passed");

  c_prot: cover property (o_prot_wr_en);
  c_off: cover property (o_off_enter);
  c_clear: cover property (lock_reg == pmcs_pkg::PMCS_OPEN ##1
                           lock_reg == pmcs_pkg::PMCS_LOCKED);

endmodule

// ### shared/pmcs_map.svh
// Register offsets, field positions and constant values of the bank
`ifndef PMCS_MAP_SVH
`define PMCS_MAP_SVH

`define PMCS_ADDR_DUTY 8'h08
`define PMCS_ADDR_MUX 8'h09
`define PMCS_ADDR_STATUS 8'h0A
`define PMCS_ADDR_UNLOCK 8'h0B
`define PMCS_ADDR_RAILGOOD 8'h0C
`define PMCS_PROT_LO 8'h0D
`define PMCS_PROT_HI 8'h1F

`define PMCS_RESET_BYTE 8'h00
`define PMCS_RESET_DUTY 7'h00
`define PMCS_UNLOCK_CODE 8'h7D
`define PMCS_DUTY_LAST_CODE 7'h63
`define PMCS_DUTY_OFF 7'h00
`define PMCS_DUTY_ONE 7'h01

`define PMCS_BIT_OFF 7
`define PMCS_BIT_ADAPTER 3
`define PMCS_BIT_USB 2
`define PMCS_BIT_BUTTON 0
`define PMCS_DUTY_W 7
`define PMCS_RAIL_W 7
`define PMCS_SRC_W 5

`endif

// ### shared/pmcs_pkg.sv
// Types shared by the control and status register bank
package pmcs_pkg;

  typedef enum logic [2:0] {
    PMCS_MUX_OFF = 3'h0,
    PMCS_MUX_BATT = 3'h1,
    PMCS_MUX_SYS = 3'h2,
    PMCS_MUX_TEMP = 3'h3,
    PMCS_MUX_CHG = 3'h4,
    PMCS_MUX_EXT = 3'h5,
    PMCS_MUX_OFF6 = 3'h6,
    PMCS_MUX_OFF7 = 3'h7
  } pmcs_mux_t;

  // Gray order along LOCKED -> ARMED -> OPEN
  typedef enum logic [1:0] {
    PMCS_LOCKED = 2'h0,
    PMCS_ARMED = 2'h1,
    PMCS_OPEN = 2'h3
  } pmcs_lock_t;

endpackage

// ### tb/pmcs_host.sv
// Host model issuing register strobes and transaction ends
`timescale 1ns/1ps

module pmcs_host (
  input wire logic i_ref_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_xfer_done
);
  initial begin
    {o_wr_en, o_rd_en, o_xfer_done} = 3'h0;
    o_addr = 8'hFF;
    o_wdata = 8'hFF;
  end

  task automatic idle(input int n);
    if (n > 0) begin
      repeat (n) @(posedge i_ref_clk);
      #1;
    end
  endtask

  // Released bus shows inverse data
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_wr_en = w;
    o_rd_en = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1;
    {o_wr_en, o_rd_en} = 2'h0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  // off request and unlock are host writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    op(1'b0, a, 8'hA5);
  endtask

  task automatic done();
    @(posedge i_ref_clk);
    #1;
    o_xfer_done = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_xfer_done = 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the control and status register bank
`timescale 1ns/1ps

module tb;
  logic clk, rst, power_enable_in, ac, usb, btn, mux_en, off_enter, pw_en;
  logic wr_en, rd_en, xd_en;
  logic [6:0] rail, duty_pct;
  logic [7:0] addr, wdata, rdata, pw_addr, pw_data, a, d;
  logic [2:0] sel;
  logic [4:0] src;
  int mismatches, num_checks, m_duty, m_mux, m_off, m_pw, m_dn, m_open, k;
  logic [7:0] amap [0:8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
    8'h1F, 8'h20, 8'hFF};
  logic [15:0] seq [0:16] = '{16'h0B7D, 16'h0D55, 16'h0E66, 16'h0B7C,
    16'h0D11, 16'h0B7D, 16'h0812, 16'h1F22, 16'h0B7D, 16'h1F33, 16'h0BFF,
    16'h0D44, 16'h0B00, 16'h0863, 16'h0864, 16'h08FF, 16'h0862};

  pmcs_host i_host (.i_ref_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata), .o_xfer_done(xd_en));

  pmcs_regs i_dut (.i_ref_clk(clk), .i_reset(rst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_xfer_done(xd_en),
    .i_power_enable_in(power_enable_in), .i_adapter_present(ac),
    .i_usb_supply_present(usb), .i_button_input(btn), .i_rail_good(rail),
    .o_rdata(rdata), .o_duty_percent(duty_pct),
    .o_monitor_select_code(sel), .o_mux_enable(mux_en),
    .o_mux_source(src), .o_off_enter(off_enter), .o_prot_wr_en(pw_en),
    .o_prot_wr_addr(pw_addr), .o_prot_wr_data(pw_data));

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic r(input logic [7:0] ad);
    i_host.rd(ad);
    case (ad)
      8'h08: chk("duty_reg", 8'(m_duty), rdata);
      8'h09: chk("mux_reg", 8'(m_mux), rdata);
      8'h0A: chk("status", {m_off[0], 3'h0, ac, usb, 1'b0, ~btn}, rdata);
      8'h0B: chk("unlock", 8'(m_pw), rdata);
      8'h0C: chk("rail", {1'b0, rail}, rdata);
      default: chk("unmapped", 8'h00, rdata);
    endcase
  endtask

  task automatic w(input logic [7:0] ad, input logic [7:0] dt);
    logic p;
    p = m_open && ad >= 8'h0D && ad <= 8'h1F;
    i_host.wr(ad, dt);
    m_open = (ad == 8'h0B) && (dt == 8'h7D);
    if (ad == 8'h0B) begin
      m_pw = dt;
      m_dn = 0;
    end
    if (ad == 8'h08) m_duty = dt[6:0];
    if (ad == 8'h09) m_mux = dt[2:0];
    if (ad == 8'h0A && dt[7]) m_off = 1;
    chk("prot_wr_en", {7'h0, p}, {7'h0, pw_en});
    if (p) chk("prot_addr", ad, pw_addr);
    if (p) chk("prot_data", dt, pw_data);
    chk("duty_pct", 8'(m_duty < 100 ? m_duty + 1 : 0), {1'b0, duty_pct});
    chk("sel", 8'(m_mux), {5'h0, sel});
    chk("mux_en", 8'(m_mux inside {[1:5]}), {7'h0, mux_en});
    chk("src", 8'(m_mux inside {[1:5]} ? 1 << (m_mux - 1) : 0), {3'h0, src});
  endtask

  task automatic xd();
    i_host.done();
    if (m_dn < 2) m_dn++;
    if (m_dn == 2) begin
      m_pw = 0;
      m_open = 0;
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #800000;
    mismatches++;
    final_report();
  end

  initial begin
    {rst, power_enable_in, ac, usb, btn, rail} = {4'hD, 1'b1, 7'h00};
    {m_duty, m_mux, m_off, m_pw, m_dn, m_open} = {32'd0, 32'd0, 32'd0,
      32'd0, 32'd2, 32'd0};
    void'($urandom(32'h5bb5f7ee));
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk("duty_rst", 8'h01, {1'b0, duty_pct});
    for (k = 8; k < 13; k++) r(8'(k));
    for (k = 0; k < 17; k++) w(seq[k][15:8], seq[k][7:0]);
    w(8'h0B, 8'h7D);
    xd();
    r(8'h0B);
    xd();
    r(8'h0B);
    w(8'h0D, 8'h5A);
    for (k = 0; k < 8; k++) begin
      w(8'h09, 8'(k) | 8'hF8);
      r(8'h09);
      {ac, usb, btn} = 3'(k);
      rail = 7'(k * 19);
      w(8'h0A, 8'h7F);
      r(8'h0A);
      w(8'h0C, 8'hFF);
      r(8'h0C);
    end
    for (k = 0; k < 2; k++) begin
      power_enable_in = 1'(k);
      w(8'h0A, 8'h80);
      if (k == 1) begin
        r(8'h0A);
        chk("off_hold", 8'h00, {7'h0, off_enter});
      end
      power_enable_in = 1'b0;
      chk("off_enter", 8'h00, {7'h0, off_enter});
      i_host.idle(1);
      chk("off_enter", 8'h01, {7'h0, off_enter});
      m_off = 0;
      r(8'h0A);
    end
    power_enable_in = 1'b1;
    for (k = 0; k < 300; k++) begin
      {ac, usb, btn} = 3'($urandom);
      rail = 7'($urandom);
      a = amap[$urandom % 9];
      d = ($urandom % 2) ? 8'h7D : 8'($urandom);
      w(a, d);
      if ($urandom % 3 == 0) xd();
      if (a <= 8'h0C || a >= 8'h20) r(a);
      i_host.idle($urandom % 3);
    end
    final_report();
  end
endmodule
